// >>> sptm_top.sv
// Our own choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`include "sptm_cfg.svh"
// Behaviour
// [R1] pulse mode needs mode 10, io 11
// [R2] run rise starts counter, leading edge
// [R3] ext clock edge sets run bit
// [R4] software clearing run ends pulse
// [R5] compare A match clears run, flags
// [R6] counter zeroed only on run rise
// [R7] period and clear select ignored
// [R8] software holds run during pulse
// [R9] capture mode needs mode 01
// [R10] source select picks capture pin
// [R11] io select picks capture edge
// [R12] io 11 disables capture only
// [R13] run rise starts capture counter
// [R14] edge copies counter to compare A
// [R15] counter free runs until run falls
// [R16] period match wraps counter, flags
// [R17] period zero runs to max
// [R18] pin edges capture even as output
// [R19] clear, level, polarity ignored
// [R20] ten bit counter, max 3ff
// [R21] initial level applied on run rise
// [R22] flags A bit5, P bit4 separate
// [R23] io codes 00 rise 01 fall 10 both
// [R24] pins synchronised before edge detect
module sptm_top #(
  parameter int CW = 10
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // timer pins
  input wire logic ext_clock_pin,
  input wire logic capture_input_pin,
  output logic timer_out
);
  localparam logic [CW-1:0] CMAX = '1;
  sptm_pkg::sptm_wr_t wst_r;
  logic [3:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic [8:0] ctrl_r;
  logic [CW-1:0] cnt_r, cmpa_r, per_r;
  logic flag_a_r, flag_p_r, run_d_r, out_r;
  logic [1:0] ext_s_r, cap_s_r;
  logic ext_d_r, cap_d_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic bvalid_r;
  logic [1:0] bresp_r, rresp_r;

  function automatic logic sptm_hit(input logic [3:0] a, input logic [3:0] r);
    sptm_hit = (a[3:2] == r[3:2]);
  endfunction

  // write channel handshakes; a write completes when address and data arrive together, a lone beat parks and then only its own channel stays ready
  wire aw_ok = s_axi_awvalid && (wst_r == sptm_pkg::SPTM_IDLE || wst_r == sptm_pkg::SPTM_WADDR);
  wire w_ok = s_axi_wvalid && (wst_r == sptm_pkg::SPTM_IDLE || wst_r == sptm_pkg::SPTM_WDATA);
  assign s_axi_awready = aw_ok;
  assign s_axi_wready = w_ok;
  wire wr_fire = (aw_ok && w_ok) || (wst_r == sptm_pkg::SPTM_WDATA && aw_ok)
                 || (wst_r == sptm_pkg::SPTM_WADDR && w_ok);
  wire [3:0] wa = (wst_r == sptm_pkg::SPTM_WADDR) ? awaddr_r : s_axi_awaddr;
  wire [31:0] wd = (wst_r == sptm_pkg::SPTM_WDATA) ? wdata_r : s_axi_wdata;
  // strobes belong to the data beat, so a parked beat keeps its own strobes
  wire [3:0] ws = (wst_r == sptm_pkg::SPTM_WDATA) ? wstrb_r : s_axi_wstrb;
  // an unaligned address answers with an error and touches no register
  wire wr_bad = wr_fire && (wa[1:0] != 2'h0);
  wire wr_go = wr_fire && !wr_bad;
  wire wr_ctrl = wr_go && sptm_hit(wa, `SPTM_ADDR_CTRL) && ws[0];
  wire wr_ctrh = wr_go && sptm_hit(wa, `SPTM_ADDR_CTRL) && ws[1];
  wire wr_cmpa = wr_go && sptm_hit(wa, `SPTM_ADDR_CMPA);
  wire wr_per = wr_go && sptm_hit(wa, `SPTM_ADDR_PER);
  wire wr_stat = wr_go && sptm_hit(wa, `SPTM_ADDR_STAT) && ws[0];

  // write state machine
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wst_r <= sptm_pkg::SPTM_IDLE;
      awaddr_r <= 4'h0;
      wdata_r <= 32'h0;
      wstrb_r <= 4'h0;
    end else begin
      case (wst_r)
        sptm_pkg::SPTM_IDLE: begin
          if (aw_ok && w_ok) wst_r <= sptm_pkg::SPTM_WRESP;
          else if (aw_ok) begin
            wst_r <= sptm_pkg::SPTM_WADDR;
            awaddr_r <= s_axi_awaddr;
          end else if (w_ok) begin
            wst_r <= sptm_pkg::SPTM_WDATA;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
          end
        end
        sptm_pkg::SPTM_WADDR: if (w_ok) wst_r <= sptm_pkg::SPTM_WRESP;
        sptm_pkg::SPTM_WDATA: if (aw_ok) wst_r <= sptm_pkg::SPTM_WRESP;
        sptm_pkg::SPTM_WRESP: if (s_axi_bready) wst_r <= sptm_pkg::SPTM_IDLE;
        default: wst_r <= sptm_pkg::SPTM_IDLE;
      endcase
    end
  end

  // write response; stays until bready
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= 2'h0;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_bad ? 2'h2 : 2'h0;
    end else if (bvalid_r && s_axi_bready) bvalid_r <= 1'b0;
  end
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;

  // pin synchronisers; only the second stage feeds edge detection
  // [R24] two-stage sync
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_s_r <= 2'h0;
      cap_s_r <= 2'h0;
      ext_d_r <= 1'b0;
      cap_d_r <= 1'b0;
    end else begin
      ext_s_r <= {ext_s_r[0], ext_clock_pin};
      cap_s_r <= {cap_s_r[0], capture_input_pin};
      ext_d_r <= ext_s_r[1];
      cap_d_r <= cap_s_r[1];
    end
  end

  // mode decode
  wire [1:0] mode = {ctrl_r[`SPTM_MODE_HI], ctrl_r[`SPTM_MODE_LO]};
  wire [1:0] io = {ctrl_r[`SPTM_IO_HI], ctrl_r[`SPTM_IO_LO]};
  wire run = ctrl_r[`SPTM_RUN_BIT];
  // [R1] pulse mode decode
  wire pulse_mode = (mode == `SPTM_MODE_PULSE) && (io == `SPTM_IO_NONE);
  // [R9] capture mode decode
  wire cap_mode = (mode == `SPTM_MODE_CAP);
  wire run_rise = run && !run_d_r;
  wire ext_rise = ext_s_r[1] && !ext_d_r;
  wire ext_fall = !ext_s_r[1] && ext_d_r;
  // [R10] capture source mux, pin used regardless of direction elsewhere
  wire src_now = ctrl_r[`SPTM_CKS_BIT] ? ext_s_r[1] : cap_s_r[1];
  wire src_old = ctrl_r[`SPTM_CKS_BIT] ? ext_d_r : cap_d_r;
  // [R11] [R23] edge qualification
  wire cap_edge = (io == `SPTM_IO_RISE) ? (src_now && !src_old) :
                  (io == `SPTM_IO_FALL) ? (!src_now && src_old) :
                  (io == `SPTM_IO_BOTH) ? (src_now != src_old) : 1'b0;
  // [R12] [R14] [R18] capture strobe
  wire cap_hit = cap_mode && run && cap_edge;
  // [R3] trigger on rising ext clock edge
  wire trig = pulse_mode && !run && ext_rise;
  // [R5] compare A match ends pulse
  wire a_match = pulse_mode && run && !run_rise && (cnt_r == cmpa_r);
  // [R16] [R17] period match; zero period wraps at max
  wire p_match = cap_mode && run && !run_rise && (per_r == {CW{1'b0}} ? cnt_r == CMAX : cnt_r == per_r);

  // control register: software writes, hardware sets or clears run
  always_ff @(posedge aclk) begin
    if (!aresetn) ctrl_r <= 9'h0;
    else begin
      if (wr_ctrl) ctrl_r[7:0] <= wd[7:0];
      if (wr_ctrh) ctrl_r[`SPTM_CKS_BIT] <= wd[`SPTM_CKS_BIT];
      // [R5] hardware clear wins over write
      if (a_match) ctrl_r[`SPTM_RUN_BIT] <= 1'b0;
      // [R3] trigger sets run
      else if (trig) ctrl_r[`SPTM_RUN_BIT] <= 1'b1;
    end
  end

  // counter; only runs in pulse or capture mode
  // [R2] [R6] [R13] [R15] [R20] counter control
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= {CW{1'b0}};
      run_d_r <= 1'b0;
    end else begin
      run_d_r <= run;
      if (run_rise) cnt_r <= {CW{1'b0}};
      else if (p_match) cnt_r <= {CW{1'b0}};
      else if (run && (pulse_mode || cap_mode)) cnt_r <= cnt_r + 1'b1;
    end
  end

  // output pin: initial level on run rise, inverted while pulse active
  // [R2] [R4] [R21] leading and trailing edges; [R7] [R19] clear select unused
  always_ff @(posedge aclk) begin
    if (!aresetn) out_r <= 1'b0;
    else if (pulse_mode) begin
      if (run_rise) out_r <= !ctrl_r[`SPTM_OC_BIT] ^ ctrl_r[`SPTM_POL_BIT];
      else if (!run) out_r <= ctrl_r[`SPTM_OC_BIT] ^ ctrl_r[`SPTM_POL_BIT];
    end
  end
  assign timer_out = out_r;

  // compare A, period and flags; set beats software clear
  // [R14] [R22] capture latch and flags
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmpa_r <= {CW{1'b0}};
      per_r <= {CW{1'b0}};
      flag_a_r <= 1'b0;
      flag_p_r <= 1'b0;
    end else begin
      if (cap_hit) cmpa_r <= cnt_r;
      else if (wr_cmpa) cmpa_r <= wd[CW-1:0];
      if (wr_per) per_r <= wd[CW-1:0];
      if (cap_hit || a_match) flag_a_r <= 1'b1;
      else if (wr_stat && wd[`SPTM_FLAG_A]) flag_a_r <= 1'b0;
      if (p_match) flag_p_r <= 1'b1;
      else if (wr_stat && wd[`SPTM_FLAG_P]) flag_p_r <= 1'b0;
    end
  end

  // read channel, one cycle latency
  wire [3:0] ra = s_axi_araddr;
  // status word: counter copy above, the two match flags below
  wire [31:0] stat_word = ({{(32-CW){1'b0}}, cnt_r} << `SPTM_CNT_LSB) |
                          ({31'h0, flag_a_r} << `SPTM_FLAG_A) |
                          ({31'h0, flag_p_r} << `SPTM_FLAG_P);
  wire [31:0] rd_mux = sptm_hit(ra, `SPTM_ADDR_CTRL) ? {23'h0, ctrl_r} :
                       sptm_hit(ra, `SPTM_ADDR_CMPA) ? {{(32-CW){1'b0}}, cmpa_r} :
                       sptm_hit(ra, `SPTM_ADDR_PER) ? {{(32-CW){1'b0}}, per_r} :
                       stat_word;
  assign s_axi_arready = !rvalid_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0;
      rresp_r <= 2'h0;
    end else if (s_axi_arvalid && !rvalid_r) begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_mux;
      rresp_r <= (ra[1:0] != 2'h0) ? 2'h2 : 2'h0;
    end else if (s_axi_rready) rvalid_r <= 1'b0;
  end
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  // checks
  property p_amatch;
    @(posedge aclk) disable iff (!aresetn) a_match |=> !run && flag_a_r;
  endproperty
  a_amatch: assert property (p_amatch) else $error("compare A did not stop pulse"); // [R5]
  property p_trig;
    @(posedge aclk) disable iff (!aresetn) (trig && !wr_ctrl) |=> run ##1 cnt_r == 0;
  endproperty
  a_trig: assert property (p_trig) else $error("trigger did not start counter"); // [R3]
  property p_cap;
    @(posedge aclk) disable iff (!aresetn) cap_hit |=> cmpa_r == $past(cnt_r) && flag_a_r;
  endproperty
  a_cap: assert property (p_cap) else $error("capture value wrong"); // [R14]
  property p_nocap;
    @(posedge aclk) disable iff (!aresetn) (io == `SPTM_IO_NONE) |-> !cap_hit;
  endproperty
  a_nocap: assert property (p_nocap) else $error("capture with io 11"); // [R12]
  property p_wrap;
    @(posedge aclk) disable iff (!aresetn) p_match && !run_rise |=> cnt_r == 0 && flag_p_r;
  endproperty
  a_wrap: assert property (p_wrap) else $error("period wrap wrong"); // [R16]
  property p_max;
    @(posedge aclk) disable iff (!aresetn)
      cap_mode && run && !run_rise && per_r == 0 && cnt_r == CMAX |=> cnt_r == 0 && flag_p_r;
  endproperty
  a_max: assert property (p_max) else $error("no wrap at max"); // [R17]
  property p_rise;
    @(posedge aclk) disable iff (!aresetn) run_rise |=> cnt_r == 0;
  endproperty
  a_rise: assert property (p_rise) else $error("counter not zeroed on start"); // [R6]
  // levels taken from the cycle of the start, so a same-cycle write cannot confuse the check
  property p_lead;
    @(posedge aclk) disable iff (!aresetn)
      pulse_mode && run_rise |=> timer_out == !($past(ctrl_r[`SPTM_OC_BIT]) ^ $past(ctrl_r[`SPTM_POL_BIT]));
  endproperty
  a_lead: assert property (p_lead) else $error("leading edge wrong"); // [R21]
  // [R4] trailing edge level
  property p_trail;
    @(posedge aclk) disable iff (!aresetn)
      pulse_mode && !run |=> timer_out == ($past(ctrl_r[`SPTM_OC_BIT]) ^ $past(ctrl_r[`SPTM_POL_BIT]));
  endproperty
  a_trail: assert property (p_trail) else $error("trailing edge wrong"); // [R4]
  property p_bresp;
    @(posedge aclk) disable iff (!aresetn) wr_fire |=> s_axi_bvalid;
  endproperty
  a_bresp: assert property (p_bresp) else $error("no write response"); // AXI4-Lite write response, our own choice
  c_pulse: cover property (@(posedge aclk) disable iff (!aresetn) a_match);
  c_cap: cover property (@(posedge aclk) disable iff (!aresetn) cap_hit);
  c_wrap: cover property (@(posedge aclk) disable iff (!aresetn) p_match);
  c_trig: cover property (@(posedge aclk) disable iff (!aresetn) trig);
  c_max: cover property (@(posedge aclk) disable iff (!aresetn) cap_mode && per_r == 0 && p_match);
endmodule // sptm_top

// >>> sptm_cfg.svh
`ifndef SPTM_CFG_SVH
`define SPTM_CFG_SVH
// register byte addresses
`define SPTM_ADDR_CTRL 4'h0
`define SPTM_ADDR_CMPA 4'h4
`define SPTM_ADDR_PER 4'h8
`define SPTM_ADDR_STAT 4'hc
// control field positions
`define SPTM_RUN_BIT 0
`define SPTM_MODE_LO 1
`define SPTM_MODE_HI 2
`define SPTM_IO_LO 3
`define SPTM_IO_HI 4
`define SPTM_CLR_BIT 5
`define SPTM_OC_BIT 6
`define SPTM_POL_BIT 7
`define SPTM_CKS_BIT 8
// status flag positions
`define SPTM_FLAG_P 4
`define SPTM_FLAG_A 5
// lowest bit of the read-only counter copy in the status word
`define SPTM_CNT_LSB 16
// mode and edge codes
`define SPTM_MODE_CAP 2'h1
`define SPTM_MODE_PULSE 2'h2
`define SPTM_IO_RISE 2'h0
`define SPTM_IO_FALL 2'h1
`define SPTM_IO_BOTH 2'h2
`define SPTM_IO_NONE 2'h3
`endif

// >>> sptm_pkg.sv
package sptm_pkg;
  typedef enum logic [1:0] {SPTM_IDLE, SPTM_WDATA, SPTM_WADDR, SPTM_WRESP} sptm_wr_t;
endpackage

// >>> sptm_pins.sv
`timescale 1ns/1ps
// far side: the two timer input pins, always at a defined level
module sptm_pins (
  // timer pins
  output logic ext_clock_pin,
  output logic capture_input_pin
);
  // both pins rest low so a first rise is a clean edge
  initial begin
    ext_clock_pin = 1'b0;
    capture_input_pin = 1'b0;
  end
  // call just after a rising edge; the change lands by nba and never races the sampler
  task automatic set_pin(input bit ext, input bit v);
    if (ext) begin
      ext_clock_pin <= v;
    end else begin
      capture_input_pin <= v;
    end
  endtask
endmodule // sptm_pins

// >>> sptm_bench.sv
`timescale 1ns/1ps
`include "sptm_cfg.svh"
module sptm_bench;
  logic aclk;
  logic aresetn;
  logic [3:0] awaddr, araddr;
  logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic timer_out, ext_pin, cap_pin;
  logic [31:0] wdata, rdata, d, c1, c2;
  logic [1:0] bresp, rresp, r, rr;
  int error_cnt = 0;
  int n_tests = 0;
  int cyc = 0;
  int t0;
  bit rise_e, fall_e;

  sptm_top #(.CW(10)) uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ext_clock_pin(ext_pin),
    .capture_input_pin(cap_pin), .timer_out(timer_out));
  sptm_pins pins (.ext_clock_pin(ext_pin), .capture_input_pin(cap_pin));

  // 100 mhz clock
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // hang guard, generous against roughly 1600 cycles of traffic
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      error_cnt++;
      conclude();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // aw and w offered together, each dropped at the edge that takes it
  task automatic wr(input logic [3:0] a, input logic [31:0] dv, output logic [1:0] resp);
    bit aw_done, w_done;
    aw_done = 0;
    w_done = 0;
    awaddr <= a;
    wdata <= dv;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        aw_done = 1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        w_done = 1;
        wvalid <= 1'b0;
      end
    end
    // bready stays up between writes; dropping and raising it in one step would drive it twice
    do @(posedge aclk); while (!bvalid);
    resp = bresp;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] dv);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    // rready stays up between reads for the same reason as bready
    dv = rdata;
    rr = rresp;
  endtask

  function automatic logic [31:0] ctl(bit run, logic [1:0] md, logic [1:0] io, bit cks, logic [2:0] x);
    return {23'h0, cks, x, io, md, run};
  endfunction

  // one pin change, then the match-a flag after the 3-edge sync delay, then clear flags
  task automatic try_edge(input bit ext, input bit v, input bit exp);
    logic [31:0] dv;
    logic [1:0] rs;
    pins.set_pin(ext, v);
    repeat (6) @(posedge aclk);
    rd(`SPTM_ADDR_STAT, dv);
    chk("capture_flag", {31'h0, dv[`SPTM_FLAG_A]}, {31'h0, exp});
    wr(`SPTM_ADDR_STAT, 32'h30, rs);
  endtask

  initial begin
    {awaddr, araddr, awvalid, wvalid, bready, arvalid, rready, wdata} = '0;
    aresetn = 1'b0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      rd(4'(i * 4), d);
      chk("reset_value", d, 32'h0);
      chk("read_resp", {30'h0, rr}, 32'h0);
    end
    // unaligned accesses answer with an error and must not land
    wr(4'h2, 32'h1f, r);
    chk("unaligned_resp", {30'h0, r}, 32'h2);
    rd(`SPTM_ADDR_CTRL, d);
    chk("unaligned_nowrite", d, 32'h0);
    rd(4'h6, d);
    chk("unaligned_rresp", {30'h0, rr}, 32'h2);
    // every edge code on both sources; wrong-pin edges and control junk must not count
    for (int s = 0; s < 2; s++) begin
      for (int io = 0; io < 4; io++) begin
        rise_e = (io == 0 || io == 2);
        fall_e = (io == 1 || io == 2);
        wr(`SPTM_ADDR_CTRL, ctl(1, `SPTM_MODE_CAP, io[1:0], s[0], 3'h7), r);
        wr(`SPTM_ADDR_STAT, 32'h30, r);
        try_edge(!s[0], 1'b1, 1'b0);
        try_edge(s[0], 1'b1, rise_e);
        try_edge(!s[0], 1'b0, 1'b0);
        try_edge(s[0], 1'b0, fall_e);
        if (io == 3) begin
          rd(`SPTM_ADDR_STAT, c1);
          rd(`SPTM_ADDR_STAT, c2);
          chk("count_runs", {31'h0, c1[25:16] !== c2[25:16]}, 32'h1);
        end
      end
    end
    // two captures a known 40 cycles apart
    wr(`SPTM_ADDR_PER, 32'h0, r);
    chk("write_resp", {30'h0, r}, 32'h0);
    wr(`SPTM_ADDR_CTRL, ctl(0, `SPTM_MODE_CAP, `SPTM_IO_BOTH, 0, 3'h0), r);
    wr(`SPTM_ADDR_CTRL, ctl(1, `SPTM_MODE_CAP, `SPTM_IO_BOTH, 0, 3'h0), r);
    t0 = cyc;
    pins.set_pin(0, 1'b1);
    repeat (6) @(posedge aclk);
    rd(`SPTM_ADDR_CMPA, c1);
    while (cyc < t0 + 40) @(posedge aclk);
    pins.set_pin(0, 1'b0);
    repeat (6) @(posedge aclk);
    rd(`SPTM_ADDR_CMPA, c2);
    chk("capture_gap", {22'h0, c2[9:0] - c1[9:0]}, 32'd40);
    // zero period: restart, no wrap well before the all-ones count, one wrap just after it
    wr(`SPTM_ADDR_CTRL, ctl(0, `SPTM_MODE_CAP, `SPTM_IO_NONE, 0, 3'h0), r);
    wr(`SPTM_ADDR_CTRL, ctl(1, `SPTM_MODE_CAP, `SPTM_IO_NONE, 0, 3'h0), r);
    wr(`SPTM_ADDR_STAT, 32'h30, r);
    repeat (1000) @(posedge aclk);
    rd(`SPTM_ADDR_STAT, d);
    chk("no_early_wrap", {31'h0, d[`SPTM_FLAG_P]}, 32'h0);
    repeat (30) @(posedge aclk);
    rd(`SPTM_ADDR_STAT, d);
    chk("wrap_at_max", {31'h0, d[`SPTM_FLAG_P]}, 32'h1);
    // period bounds the count; restart first, as a count already past the period runs to overflow
    wr(`SPTM_ADDR_PER, 32'h5, r);
    wr(`SPTM_ADDR_CTRL, ctl(0, `SPTM_MODE_CAP, `SPTM_IO_NONE, 0, 3'h0), r);
    wr(`SPTM_ADDR_CTRL, ctl(1, `SPTM_MODE_CAP, `SPTM_IO_NONE, 0, 3'h0), r);
    wr(`SPTM_ADDR_STAT, 32'h30, r);
    repeat (20) @(posedge aclk);
    rd(`SPTM_ADDR_STAT, d);
    chk("period_flag", {31'h0, d[`SPTM_FLAG_P]}, 32'h1);
    chk("count_bound", {31'h0, d[25:16] <= 10'h5}, 32'h1);
    // single pulse by software; period 5 and clear select must be ignored
    wr(`SPTM_ADDR_CTRL, ctl(0, `SPTM_MODE_PULSE, `SPTM_IO_NONE, 0, 3'h1), r);
    wr(`SPTM_ADDR_CMPA, 32'd40, r);
    wr(`SPTM_ADDR_STAT, 32'h30, r);
    wr(`SPTM_ADDR_CTRL, ctl(1, `SPTM_MODE_PULSE, `SPTM_IO_NONE, 0, 3'h1), r);
    repeat (10) @(posedge aclk);
    chk("lead_edge", {31'h0, timer_out}, 32'h1);
    repeat (60) @(posedge aclk);
    chk("trail_edge", {31'h0, timer_out}, 32'h0);
    rd(`SPTM_ADDR_CTRL, d);
    chk("run_cleared", {31'h0, d[`SPTM_RUN_BIT]}, 32'h0);
    rd(`SPTM_ADDR_STAT, d);
    chk("pulse_flag", {26'h0, d[5:4]}, 32'h2);
    // pin trigger, then software ends the pulse early
    pins.set_pin(1, 1'b1);
    repeat (8) @(posedge aclk);
    chk("pin_lead", {31'h0, timer_out}, 32'h1);
    rd(`SPTM_ADDR_CTRL, d);
    chk("pin_run", {31'h0, d[`SPTM_RUN_BIT]}, 32'h1);
    wr(`SPTM_ADDR_CTRL, ctl(0, `SPTM_MODE_PULSE, `SPTM_IO_NONE, 0, 3'h1), r);
    repeat (3) @(posedge aclk);
    chk("sw_trail", {31'h0, timer_out}, 32'h0);
    pins.set_pin(1, 1'b0);
    conclude();
  end
endmodule // sptm_bench
